// ---- rtl/pcs_unit.sv ----
// program counter, return stack and status register of the core
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
module pcs_unit
	import pcs_pkg::*;
#(
	parameter int DEPTH = STACK_DEPTH
) (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// apb slave
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [APB_DW-1:0] pwdata,
	output logic [APB_DW-1:0] prdata,
	output logic pready,
	output logic pslverr,
	// instruction stream
	input wire logic op_valid,
	input wire pcs_req_t op_req,
	output logic op_ready,
	// alu and system events
	input wire pcs_alu_t alu_flags,
	input wire logic wake_evt,
	input wire logic wdt_timeout,
	input wire logic branch_cycle_option,
	// program store side
	output logic [ROM_AW-1:0] rom_addr,
	output logic [PC_W-1:0] pc_value,
	output logic [LOW_W-1:0] exit_literal,
	output logic ctrl_segment_select,
	output logic page_select_bit
);

	localparam int SP_W = $clog2(DEPTH);

	// the pointer wraps by plain overflow, so depth must be a power of two
	if (DEPTH < 2 || DEPTH != (1 << SP_W)) begin : g_chk
		$error("pcs_unit: DEPTH must be a power of two, at least 2");
	end

	// register decode, shared by read and write paths
	function automatic pcs_sel_t reg_sel(input logic [ADDR_W-1:0] a);
		if (a == ADDR_W'(IDX_PC_LOW << 2)) begin
			return SEL_PC;
		end else if (a == ADDR_W'(IDX_STATUS << 2)) begin
			return SEL_STATUS;
		end
		return SEL_NONE;
	endfunction : reg_sel

	// state
	logic [PC_W-1:0] pc_ff;
	logic [PC_W-1:0] nxt_pc;
	logic [PC_W-1:0] stack_ff [DEPTH];
	logic [SP_W-1:0] sp_ff;
	logic stall_ff;
	logic [7:0] status_ff;
	logic [APB_DW-1:0] prdata_ff;
	logic [LOW_W-1:0] literal_ff;

	// handshakes
	logic op_fire;
	logic apb_wr;
	logic apb_access;
	logic writes_pc;
	logic is_ret;
	pcs_sel_t sel;
	logic [PC_W-1:0] top_entry;
	logic [PC_W-1:0] pc_inc;
	logic page_now;

	assign sel = reg_sel(paddr);
	assign page_now = status_ff[ST_PAGE];
	assign top_entry = stack_ff[sp_ff - SP_W'(1)];
	assign pc_inc = pc_ff + PC_ONE;

	// a counter-writing op may cost a dead cycle after it
	assign op_ready = !stall_ff;
	assign op_fire = op_valid && op_ready;

	// apb waits while an instruction is retired, so the core never
	// races a software write; a busy core can hold the bus off
	assign apb_access = psel && penable;
	assign pready = !op_fire;
	assign apb_wr = apb_access && pwrite && pready;
	assign pslverr = apb_access && (sel == SEL_NONE);

	// classes that rewrite the counter
	always_comb begin
		is_ret = 1'b0;
		writes_pc = 1'b0;
		unique case (op_req.op)
			OP_RET, OP_EXIT_WITH_LITERAL_OP, OP_INTERRUPT_EXIT_OP: begin
				is_ret = 1'b1;
				writes_pc = 1'b1;
			end
			OP_JUMP, OP_CALL, OP_ADDPC, OP_MOVPC: begin
				writes_pc = 1'b1;
			end
			default: begin
				is_ret = 1'b0;
			end
		endcase
	end

	// next counter value
	always_comb begin
		nxt_pc = pc_ff;
		if (op_fire) begin
			unique case (op_req.op)
				OP_JUMP, OP_CALL: begin
					// target fills the page, page bit picks the page
					nxt_pc = {pc_ff[PC_W-1:PAGE_BIT+1], page_now, op_req.target};
				end
				OP_RET, OP_EXIT_WITH_LITERAL_OP, OP_INTERRUPT_EXIT_OP: begin
					// whole counter from the stack, page bit untouched
					nxt_pc = top_entry;
				end
				OP_ADDPC: begin
					// full-width add so the carry walks upward
					nxt_pc = pc_ff + {{(PC_W-LOW_W){1'b0}}, op_req.acc};
				end
				OP_MOVPC: begin
					// low byte only, bits 8-9 held, page bit copied
					nxt_pc = {pc_ff[PC_W-1:PAGE_BIT+1], page_now,
						pc_ff[PAGE_BIT-1:LOW_W], op_req.acc};
				end
				default: begin
					nxt_pc = pc_inc;
				end
			endcase
		end else if (apb_wr && sel == SEL_PC) begin
			// software write acts like the accumulator move
			nxt_pc = {pc_ff[PC_W-1:PAGE_BIT+1], page_now,
				pc_ff[PAGE_BIT-1:LOW_W], pwdata[LOW_W-1:0]};
		end
	end

	// counter register
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pc_ff <= PC_RST;
		end else begin
			pc_ff <= nxt_pc;
		end
	end

	// store address is the low eleven bits
	assign rom_addr = pc_ff[ROM_AW-1:0];
	assign pc_value = pc_ff;

	// dead cycle after a counter write when the option asks for it
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			stall_ff <= 1'b0;
		end else begin
			stall_ff <= op_fire && writes_pc && branch_cycle_option;
		end
	end

	// return stack pointer, wraps silently on overflow
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sp_ff <= '0;
		end else if (op_fire && op_req.op == OP_CALL) begin
			sp_ff <= sp_ff + SP_W'(1);
		end else if (op_fire && is_ret) begin
			sp_ff <= sp_ff - SP_W'(1);
		end
	end

	// stack entries, one slot per level
	for (genvar i = 0; i < DEPTH; i++) begin : g_stack
		always_ff @(posedge clk or negedge arst_n) begin
			if (!arst_n) begin
				stack_ff[i] <= PC_RST;
			end else if (op_fire && op_req.op == OP_CALL && sp_ff == SP_W'(i)) begin
				// push the address after the call
				stack_ff[i] <= pc_inc;
			end
		end
	end

	// literal carried back by the literal return
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			literal_ff <= '0;
		end else if (op_fire && op_req.op == OP_EXIT_WITH_LITERAL_OP) begin
			literal_ff <= op_req.acc;
		end
	end
	assign exit_literal = literal_ff;

	// reset-type bit: wake sets it, any reset clears it
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			status_ff[ST_RESET_TYPE] <= STATUS_RST[ST_RESET_TYPE];
		end else if (wake_evt) begin
			status_ff[ST_RESET_TYPE] <= 1'b1;
		end
	end

	// segment and page select, software owned
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			status_ff[ST_SEGMENT] <= STATUS_RST[ST_SEGMENT];
			status_ff[ST_PAGE] <= STATUS_RST[ST_PAGE];
		end else if (apb_wr && sel == SEL_STATUS) begin
			status_ff[ST_SEGMENT] <= pwdata[ST_SEGMENT];
			status_ff[ST_PAGE] <= pwdata[ST_PAGE];
		end
	end

	// time-out: instruction set wins over a same-cycle timeout
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			status_ff[ST_TIMEOUT] <= STATUS_RST[ST_TIMEOUT];
		end else if (op_fire && (op_req.op == OP_DOZE || op_req.op == OP_KICK)) begin
			status_ff[ST_TIMEOUT] <= 1'b1;
		end else if (wdt_timeout) begin
			status_ff[ST_TIMEOUT] <= 1'b0;
		end
	end

	// power-down bit
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			status_ff[ST_PWRDOWN] <= STATUS_RST[ST_PWRDOWN];
		end else if (op_fire && op_req.op == OP_KICK) begin
			status_ff[ST_PWRDOWN] <= 1'b1;
		end else if (op_fire && op_req.op == OP_DOZE) begin
			status_ff[ST_PWRDOWN] <= 1'b0;
		end
	end

	// arithmetic flags; alu result beats a software write
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			status_ff[ST_ZERO] <= STATUS_RST[ST_ZERO];
			status_ff[ST_HALF] <= STATUS_RST[ST_HALF];
			status_ff[ST_CARRY] <= STATUS_RST[ST_CARRY];
		end else if (op_fire && op_req.op == OP_ALU) begin
			status_ff[ST_ZERO] <= alu_flags.zero;
			status_ff[ST_HALF] <= alu_flags.half;
			status_ff[ST_CARRY] <= alu_flags.carry;
		end else if (apb_wr && sel == SEL_STATUS) begin
			status_ff[ST_ZERO] <= pwdata[ST_ZERO];
			status_ff[ST_HALF] <= pwdata[ST_HALF];
			status_ff[ST_CARRY] <= pwdata[ST_CARRY];
		end
	end

	assign ctrl_segment_select = status_ff[ST_SEGMENT];
	assign page_select_bit = status_ff[ST_PAGE];

	// read data sampled every cycle; unmapped reads return zero
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			prdata_ff <= RD_ZERO;
		end else begin
			unique case (sel)
				SEL_PC: prdata_ff <= {{(APB_DW-LOW_W){1'b0}}, pc_ff[LOW_W-1:0]};
				SEL_STATUS: prdata_ff <= {{(APB_DW-8){1'b0}}, status_ff};
				default: prdata_ff <= RD_ZERO;
			endcase
		end
	end
	assign prdata = prdata_ff;

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	a_jump_target: assert property (
		op_fire && op_req.op == OP_JUMP |=>
		pc_ff[PAGE_W-1:0] == $past(op_req.target)
		&& pc_ff[PAGE_BIT] == $past(page_now))
		else $error("jump target not loaded");

	a_call_push: assert property (
		op_fire && op_req.op == OP_CALL |=>
		stack_ff[$past(sp_ff)] == $past(pc_inc) && sp_ff == $past(sp_ff) + SP_W'(1))
		else $error("call did not push next address");

	a_call_return: assert property (
		op_fire && is_ret |=> pc_ff == $past(top_entry))
		else $error("return missed stack top");

	a_ret_keeps_page: assert property (
		op_fire && is_ret && !apb_wr |=> $stable(status_ff[ST_PAGE]))
		else $error("return changed page bit");

	a_rel_add: assert property (
		op_fire && op_req.op == OP_ADDPC |=>
		pc_ff == $past(pc_ff) + {{(PC_W-LOW_W){1'b0}}, $past(op_req.acc)})
		else $error("relative add wrong");

	a_mov_low: assert property (
		op_fire && op_req.op == OP_MOVPC |=>
		pc_ff[LOW_W-1:0] == $past(op_req.acc)
		&& pc_ff[PAGE_BIT-1:LOW_W] == $past(pc_ff[PAGE_BIT-1:LOW_W]))
		else $error("byte move touched bits 8-9");

	a_branch_stall: assert property (
		op_fire && writes_pc && branch_cycle_option |=> !op_ready ##1 op_ready)
		else $error("branch cycle count wrong");

	a_one_cycle: assert property (
		op_fire && !(writes_pc && branch_cycle_option) |=> op_ready)
		else $error("unexpected stall");

	a_doze_flags: assert property (
		op_fire && op_req.op == OP_DOZE |=>
		status_ff[ST_TIMEOUT] && !status_ff[ST_PWRDOWN])
		else $error("doze flags wrong");

	a_wdt_clear: assert property (
		wdt_timeout && !(op_fire && (op_req.op == OP_DOZE || op_req.op == OP_KICK))
		|=> !status_ff[ST_TIMEOUT])
		else $error("timeout not cleared");

	a_kick_flags: assert property (
		op_fire && op_req.op == OP_KICK |=>
		status_ff[ST_TIMEOUT] && status_ff[ST_PWRDOWN])
		else $error("kick flags wrong");

	a_wake_type: assert property (
		wake_evt |=> status_ff[ST_RESET_TYPE])
		else $error("wake not recorded");

	a_alu_flags: assert property (
		op_fire && op_req.op == OP_ALU |=>
		status_ff[ST_ZERO:ST_CARRY] == $past({alu_flags.zero, alu_flags.half, alu_flags.carry}))
		else $error("alu flags not captured");

	a_rom_addr: assert property (
		op_fire && (op_req.op == OP_JUMP || op_req.op == OP_CALL) |=>
		rom_addr[PAGE_BIT] == $past(page_select_bit))
		else $error("store address mismatch");

	// plain instructions just walk to the next word
	a_pc_step: assert property (
		op_fire && !writes_pc |=> pc_ff == $past(pc_inc))
		else $error("counter did not step by one");

	a_sw_pc_write: assert property (
		apb_wr && sel == SEL_PC |=>
		pc_ff[LOW_W-1:0] == $past(pwdata[LOW_W-1:0])
		&& pc_ff[PAGE_BIT:LOW_W] == {$past(page_now), $past(pc_ff[PAGE_BIT-1:LOW_W])})
		else $error("software counter write wrong");

endmodule : pcs_unit

// ---- shared/pcs_pkg.sv ----
// shared constants and types of the program counter / stack / status unit
package pcs_pkg;
	// counter geometry
	localparam int PC_W = 12;
	localparam int ROM_AW = 11;
	localparam int PAGE_W = 10;
	localparam int LOW_W = 8;
	localparam int PAGE_BIT = 10;
	localparam int PAGE_WORDS = 1024;
	localparam int ROM_WORDS = 2048;
	localparam int ROM_DW = 13;
	localparam int STACK_DEPTH = 8;
	localparam logic [PC_W-1:0] PC_RST = 12'h000;
	localparam logic [PC_W-1:0] PC_ONE = 12'h001;
	// register indexes, byte address is four times the index
	localparam logic [7:0] IDX_PC_LOW = 8'h02;
	localparam logic [7:0] IDX_STATUS = 8'h03;
	localparam int ADDR_W = 8;
	localparam int APB_DW = 32;
	localparam logic [31:0] RD_ZERO = 32'h0000_0000;
	// status field positions
	localparam int ST_RESET_TYPE = 7;
	localparam int ST_SEGMENT = 6;
	localparam int ST_PAGE = 5;
	localparam int ST_TIMEOUT = 4;
	localparam int ST_PWRDOWN = 3;
	localparam int ST_ZERO = 2;
	localparam int ST_HALF = 1;
	localparam int ST_CARRY = 0;
	// power-on value: time-out and power-down set
	localparam logic [7:0] STATUS_RST = 8'h18;
	// instruction classes that touch this unit
	typedef enum logic [3:0] {
		OP_NOP = 4'b0000,
		OP_JUMP = 4'b0001,
		OP_CALL = 4'b0010,
		OP_RET = 4'b0011,
		OP_EXIT_WITH_LITERAL_OP = 4'b0100,
		OP_INTERRUPT_EXIT_OP = 4'b0101,
		OP_ADDPC = 4'b0110,
		OP_MOVPC = 4'b0111,
		OP_DOZE = 4'b1000,
		OP_KICK = 4'b1001,
		OP_ALU = 4'b1010
	} pcs_op_t;
	// one instruction as handed over by the decoder
	typedef struct packed {
		pcs_op_t op;
		logic [PAGE_W-1:0] target;
		logic [LOW_W-1:0] acc;
	} pcs_req_t;
	// flags produced by the ALU
	typedef struct packed {
		logic zero;
		logic half;
		logic carry;
	} pcs_alu_t;
	// register decode result
	typedef enum logic [1:0] {
		SEL_NONE = 2'b00,
		SEL_PC = 2'b01,
		SEL_STATUS = 2'b10
	} pcs_sel_t;
endpackage : pcs_pkg

// ---- verification/pcs_unit_tb.sv ----
// self-checking bench of the program counter, stack and status unit
`timescale 1ns/1ps
module pcs_unit_tb;
	import pcs_pkg::*;
	logic clk, arst_n, psel, penable, pwrite, op_valid, wake_evt, wdt_timeout, opt;
	logic [ADDR_W-1:0] paddr;
	logic [APB_DW-1:0] pwdata, prdata, rd;
	logic pready, pslverr, op_ready, er, seg, page;
	pcs_req_t op_req;
	pcs_alu_t alu_flags;
	logic [ROM_AW-1:0] rom_addr;
	logic [PC_W-1:0] pc_value;
	logic [LOW_W-1:0] exit_literal;
	logic [PC_W-1:0] push_q [0:8];
	int n_fail, cmp_count;
	pcs_unit i_dut (.clk(clk), .arst_n(arst_n), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .op_valid(op_valid), .op_req(op_req),
		.op_ready(op_ready), .alu_flags(alu_flags), .wake_evt(wake_evt),
		.wdt_timeout(wdt_timeout), .branch_cycle_option(opt), .rom_addr(rom_addr),
		.pc_value(pc_value), .exit_literal(exit_literal),
		.ctrl_segment_select(seg), .page_select_bit(page));
	// 25 MHz clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task automatic complete_run();
		$display("checks %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : complete_run
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	// one apb transfer; data and error are latched at the rising edge after pready is seen high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(negedge clk);
			if (pready === 1'b1) break;
			@(posedge clk);
		end
		if (n == 20) begin
			n_fail++;
			complete_run();
		end
		@(posedge clk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(negedge clk);
	endtask : apb
	// one instruction, held until the unit accepts it
	task automatic op(input pcs_op_t o, input logic [9:0] t, input logic [7:0] a);
		int n;
		@(posedge clk);
		op_valid <= 1'b1;
		op_req <= '{o, t, a};
		for (n = 0; n < 20; n++) begin
			@(negedge clk);
			if (op_ready === 1'b1) break;
		end
		if (n == 20) begin
			n_fail++;
			complete_run();
		end
		@(posedge clk);
		op_valid <= 1'b0;
		@(negedge clk);
	endtask : op
	task automatic t_reset();
		chk("pc", 32'h0000_0000, pc_value);
		apb(1'b0, 8'h0C, 32'h0000_0000);
		chk("status", 32'h0000_0018, rd);
		apb(1'b0, 8'h08, 32'h0000_0000);
		chk("pc low", 32'h0000_0000, rd);
	endtask : t_reset
	// fixed status bits ignore writes
	task automatic t_status();
		apb(1'b1, 8'h0C, 32'h0000_00FF);
		apb(1'b0, 8'h0C, 32'h0000_0000);
		chk("status", 32'h0000_007F, rd);
		chk("segment", 32'h0000_0001, seg);
		chk("page", 32'h0000_0001, page);
		apb(1'b1, 8'h0C, 32'h0000_0020);
		apb(1'b0, 8'h0C, 32'h0000_0000);
		chk("status", 32'h0000_0038, rd);
		chk("segment", 32'h0000_0000, seg);
	endtask : t_status
	task automatic t_jump_call();
		op(OP_JUMP, 10'h155, 8'h00);
		chk("pc", 32'h0000_0555, pc_value);
		chk("rom addr", 32'h0000_0555, rom_addr);
		apb(1'b1, 8'h0C, 32'h0000_0000);
		op(OP_CALL, 10'h0AA, 8'h00);
		chk("pc", 32'h0000_00AA, pc_value);
		apb(1'b1, 8'h0C, 32'h0000_0020);
		op(OP_RET, 10'h000, 8'h00);
		chk("pc", 32'h0000_0556, pc_value);
		chk("page", 32'h0000_0001, page);
	endtask : t_jump_call
	// page bit is still one on entry
	task automatic t_branch();
		op(OP_JUMP, 10'h0F0, 8'h00);
		op(OP_ADDPC, 10'h000, 8'h20);
		chk("pc", 32'h0000_0510, pc_value);
		op(OP_ADDPC, 10'h000, 8'hF0);
		chk("pc", 32'h0000_0600, pc_value);
		op(OP_MOVPC, 10'h000, 8'h34);
		chk("pc", 32'h0000_0634, pc_value);
		apb(1'b1, 8'h0C, 32'h0000_0000);
		apb(1'b1, 8'h08, 32'h0000_0077);
		chk("pc", 32'h0000_0277, pc_value);
		apb(1'b0, 8'h08, 32'h0000_0000);
		chk("pc low", 32'h0000_0077, rd);
		op(OP_NOP, 10'h000, 8'h00);
		chk("pc", 32'h0000_0278, pc_value);
	endtask : t_branch
	// nine calls into eight slots, then nine returns of all kinds
	task automatic t_stack();
		logic [PC_W-1:0] prev;
		pcs_op_t kinds [3];
		kinds = '{OP_RET, OP_EXIT_WITH_LITERAL_OP, OP_INTERRUPT_EXIT_OP};
		op(OP_JUMP, 10'h000, 8'h00);
		prev = 12'h000;
		for (int k = 0; k < 9; k++) begin
			push_q[k] = prev + 12'h001;
			op(OP_CALL, 10'h010 + k[9:0], 8'h00);
			prev = 12'h010 + k[11:0];
		end
		for (int j = 0; j < 9; j++) begin
			op(kinds[j % 3], 10'h000, 8'h50 + j[7:0]);
			chk("pc", {20'h0_0000, push_q[(j == 8) ? 8 : 8 - j]}, pc_value);
		end
		chk("exit literal", 32'h0000_0057, exit_literal);
	endtask : t_stack
	task automatic t_stall();
		@(posedge clk) opt <= 1'b1;
		op(OP_JUMP, 10'h003, 8'h00);
		chk("op ready", 32'h0000_0000, op_ready);
		@(negedge clk);
		chk("op ready", 32'h0000_0001, op_ready);
		@(posedge clk) opt <= 1'b0;
		op(OP_JUMP, 10'h004, 8'h00);
		chk("op ready", 32'h0000_0001, op_ready);
	endtask : t_stall
	task automatic t_flags();
		@(posedge clk) alu_flags <= 3'b101;
		op(OP_ALU, 10'h000, 8'h00);
		apb(1'b0, 8'h0C, 32'h0000_0000);
		chk("status", 32'h0000_001D, rd);
		@(posedge clk) alu_flags <= 3'b010;
		op(OP_ALU, 10'h000, 8'h00);
		op(OP_DOZE, 10'h000, 8'h00);
		apb(1'b0, 8'h0C, 32'h0000_0000);
		chk("status", 32'h0000_0012, rd);
		@(posedge clk) wdt_timeout <= 1'b1;
		@(posedge clk) wdt_timeout <= 1'b0;
		apb(1'b0, 8'h0C, 32'h0000_0000);
		chk("status", 32'h0000_0002, rd);
		op(OP_KICK, 10'h000, 8'h00);
		@(posedge clk) wake_evt <= 1'b1;
		@(posedge clk) wake_evt <= 1'b0;
		apb(1'b0, 8'h0C, 32'h0000_0000);
		chk("status", 32'h0000_009A, rd);
	endtask : t_flags
	// an unmapped place answers with an error and keeps nothing
	task automatic t_unmapped();
		apb(1'b1, 8'h10, 32'h0000_00FF);
		chk("slverr", 32'h0000_0001, er);
		apb(1'b0, 8'h10, 32'h0000_0000);
		chk("unmapped data", 32'h0000_0000, rd);
		apb(1'b0, 8'h0C, 32'h0000_0000);
		chk("status", 32'h0000_009A, rd);
		chk("slverr", 32'h0000_0000, er);
	endtask : t_unmapped
	// a second reset in mid-run clears the counter and the wake mark
	task automatic t_rerun();
		@(posedge clk) arst_n <= 1'b0;
		@(negedge clk);
		chk("pc", 32'h0000_0000, pc_value);
		@(posedge clk) arst_n <= 1'b1;
		@(negedge clk);
		apb(1'b0, 8'h0C, 32'h0000_0000);
		chk("status", 32'h0000_0018, rd);
	endtask : t_rerun
	initial begin
		n_fail = 0;
		cmp_count = 0;
		arst_n = 1'b0;
		{psel, penable, pwrite, op_valid, wake_evt, wdt_timeout, opt} = '0;
		paddr = '0;
		pwdata = '0;
		op_req = '{OP_NOP, 10'h000, 8'h00};
		alu_flags = '0;
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		@(negedge clk);
		t_reset();
		t_status();
		t_jump_call();
		t_branch();
		t_stack();
		t_stall();
		t_flags();
		t_unmapped();
		t_rerun();
		complete_run();
	end
endmodule : pcs_unit_tb
